// *** tta_host.sv ***
// host model that drives the register port of the threshold block
`timescale 1ns/10ps
module tta_host (
	input  wire logic         clock,
	input  wire logic         req_ack,
	input  wire logic [15:0]  reg_rdata,
	output tta_pkg::tta_req_s req
);
	initial req = '0;
	// one pulse per access; the answer is picked up a full cycle later
	task automatic access(input logic w, input logic [7:0] idx, input logic [15:0] d,
		output logic a, output logic [15:0] q);
		@(negedge clock);
		req = '{wr: w, rd: !w, idx: idx, wdata: d};
		@(negedge clock);
		req = '0;
		a = req_ack;
		q = reg_rdata;
	endtask : access
endmodule : tta_host

// *** tta_params.svh ***
// constants for the temperature trip threshold block
`ifndef TTA_PARAMS_SVH
`define TTA_PARAMS_SVH
`define TTA_IDX_UPPER     8'h02
`define TTA_IDX_LOWER     8'h03
`define TTA_IDX_CRIT      8'h04
`define TTA_THR_RESET     11'h000
`define TTA_FLD_SIGN      12
`define TTA_FLD_MAG_HI    11
`define TTA_FLD_LSB       2
`define TTA_RSV_HI_MSB    15
`define TTA_RSV_HI_LSB    13
`define TTA_RSV_LO_MSB    1
`define TTA_RSV_LO_LSB    0
`define TTA_RSV_HI_ZERO   3'h0
`define TTA_RSV_LO_ZERO   2'h0
`define TTA_RDATA_ZERO    16'h0000
`define TTA_BIT_CLEAR     1'h0
`endif

// *** tta_pkg.sv ***
// types shared by the temperature trip threshold block
package tta_pkg;
	// threshold code: sign plus magnitude, quarter degree step
	typedef logic signed [10:0] tta_thr_t;
	// measured temperature: sign plus magnitude, eighth degree step
	typedef logic signed [11:0] tta_temp_t;
	// one register access from the serial front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] idx;
		logic [15:0] wdata;
	} tta_req_s;
	// comparison flags
	typedef struct packed {
		logic crit;
		logic upper;
		logic lower;
	} tta_flags_s;
endpackage : tta_pkg

// *** tta_thresh_reg.sv ***
// one lockable threshold register with its write decode
`timescale 1ns/10ps
`include "tta_params.svh"
module tta_thresh_reg #(
	parameter logic [7:0] IDX = `TTA_IDX_UPPER
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire tta_pkg::tta_req_s req,
	input  wire logic              locked,
	output tta_pkg::tta_thr_t      value
);
	tta_pkg::tta_thr_t value_q;
	tta_pkg::tta_thr_t value_d;
	wire               hit;
	wire               take;

	// a locked register drops the write but the transfer still ends normally
	assign hit  = req.wr && (req.idx == IDX);
	assign take = hit && !locked;
	// sign and magnitude bits are the only stored bits
	assign value_d = take ? tta_pkg::tta_thr_t'(req.wdata[`TTA_FLD_SIGN:`TTA_FLD_LSB])
		: value_q;
	assign value = value_q;

	// storage
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			value_q <= `TTA_THR_RESET;
		end else begin
			value_q <= value_d;
		end
	end

	a_locked_write_held: assert property (@(posedge clock) disable iff (!rst_n)
		hit && locked |=> value_q == $past(value_q))
		else $error("locked threshold changed on write");
	a_open_write_taken: assert property (@(posedge clock) disable iff (!rst_n)
		hit && !locked |=> value_q == $past(req.wdata[`TTA_FLD_SIGN:`TTA_FLD_LSB]))
		else $error("unlocked write not stored");
endmodule : tta_thresh_reg

// *** tta_top.sv ***
// temperature trip thresholds, locks and alarm decision
`timescale 1ns/10ps
`include "tta_params.svh"
module tta_top (
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire tta_pkg::tta_req_s  req,
	output logic                    req_ack,
	output logic [15:0]             reg_rdata,
	input  wire logic               window_lock_set,
	input  wire logic               critical_lock_set,
	output logic                    window_lock_bit,
	output logic                    critical_lock_bit,
	input  wire logic               alarm_output_enable,
	input  wire logic               critical_only,
	input  wire tta_pkg::tta_temp_t temp_value,
	input  wire logic [11:0]        hysteresis,
	output tta_pkg::tta_flags_s     trip_flags,
	output logic                    alarm_out
);
	tta_pkg::tta_thr_t   upper_threshold_value;
	tta_pkg::tta_thr_t   lower_threshold_value;
	tta_pkg::tta_thr_t   critical_threshold_value;
	tta_pkg::tta_flags_s flags_q;
	tta_pkg::tta_flags_s flags_d;
	logic                win_lock_q;
	logic                crit_lock_q;
	logic                ack_q;
	logic [15:0]         rdata_q;
	logic                alarm_q;
	wire  [15:0]         rdata_d;
	wire  [10:0]         rd_field;
	wire                 sel_upper;
	wire                 sel_lower;
	wire                 sel_crit;
	wire  signed [13:0]  t_ext;
	wire  signed [13:0]  h_ext;
	wire  signed [13:0]  up_ext;
	wire  signed [13:0]  lo_ext;
	wire  signed [13:0]  cr_ext;
	wire                 alarm_d;
	// per-access and per-flag decode terms
	wire                 access;
	wire                 sel_none;
	wire                 up_trip;
	wire                 up_keep;
	wire                 lo_trip;
	wire                 lo_keep;
	wire                 cr_trip;
	wire                 cr_keep;

	// the three threshold registers, window pair shares one lock
	tta_thresh_reg #(.IDX(`TTA_IDX_UPPER)) u_upper (
		.clock  (clock),
		.rst_n  (rst_n),
		.req    (req),
		.locked (win_lock_q),
		.value  (upper_threshold_value)
	);
	tta_thresh_reg #(.IDX(`TTA_IDX_LOWER)) u_lower (
		.clock  (clock),
		.rst_n  (rst_n),
		.req    (req),
		.locked (win_lock_q),
		.value  (lower_threshold_value)
	);
	tta_thresh_reg #(.IDX(`TTA_IDX_CRIT)) u_crit (
		.clock  (clock),
		.rst_n  (rst_n),
		.req    (req),
		.locked (crit_lock_q),
		.value  (critical_threshold_value)
	);

	// locks only ever set; reset stands in for power-on
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			win_lock_q  <= `TTA_BIT_CLEAR;
			crit_lock_q <= `TTA_BIT_CLEAR;
		end else begin
			win_lock_q  <= win_lock_q | window_lock_set;
			crit_lock_q <= crit_lock_q | critical_lock_set;
		end
	end
	assign window_lock_bit   = win_lock_q;
	assign critical_lock_bit = crit_lock_q;

	// read decode; unmapped indices read zero
	// one access term feeds the acknowledge, so locked writes answer too
	assign access    = req.wr | req.rd;
	assign sel_upper = req.idx == `TTA_IDX_UPPER;
	assign sel_lower = req.idx == `TTA_IDX_LOWER;
	assign sel_crit  = req.idx == `TTA_IDX_CRIT;
	assign sel_none  = !(sel_upper || sel_lower || sel_crit);
	assign rd_field  = sel_upper ? upper_threshold_value
		: sel_lower ? lower_threshold_value
		: sel_crit  ? critical_threshold_value : `TTA_THR_RESET;
	assign rdata_d   = {`TTA_RSV_HI_ZERO, rd_field, `TTA_RSV_LO_ZERO};

	// every access is answered one cycle later, locked or not
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_q   <= `TTA_BIT_CLEAR;
			rdata_q <= `TTA_RDATA_ZERO;
		end else begin
			ack_q   <= access;
			if (req.rd) begin
				rdata_q <= rdata_d;
			end
		end
	end
	assign req_ack   = ack_q;
	assign reg_rdata = rdata_q;

	// compare at eighth-degree scale; extra bits keep the subtraction from wrapping
	assign t_ext  = 14'(temp_value);
	assign h_ext  = 14'($signed({2'b00, hysteresis}));
	assign up_ext = 14'($signed({upper_threshold_value, 1'b0}));
	assign lo_ext = 14'($signed({lower_threshold_value, 1'b0}));
	assign cr_ext = 14'($signed({critical_threshold_value, 1'b0}));

	// trip and keep conditions; keep only matters while the flag is up
	// the band never wraps: the extra compare bits cover the full hysteresis range
	assign up_trip = t_ext > up_ext;
	assign up_keep = t_ext > up_ext - h_ext;
	assign lo_trip = t_ext < lo_ext - h_ext;
	assign lo_keep = t_ext < lo_ext;
	assign cr_trip = t_ext > cr_ext;
	assign cr_keep = t_ext > cr_ext - h_ext;

	// hysteretic trip flags: set on trip, drop once keep fails
	assign flags_d.upper = flags_q.upper ? up_keep : up_trip;
	assign flags_d.lower = flags_q.lower ? lo_keep : lo_trip;
	assign flags_d.crit  = flags_q.crit ? cr_keep : cr_trip;
	// critical-only mode masks the window pair
	assign alarm_d = alarm_output_enable && (flags_q.crit
		|| (!critical_only && (flags_q.upper || flags_q.lower)));

	// flags and pin; pin lags the flags by one cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flags_q <= '0;
			alarm_q <= `TTA_BIT_CLEAR;
		end else begin
			flags_q <= flags_d;
			alarm_q <= alarm_d;
		end
	end
	assign trip_flags = flags_q;
	assign alarm_out  = alarm_q;

	// reserved fields are tied off in the read word; this guards the concatenation
	a_reserved_read_zero: assert property (@(posedge clock) disable iff (!rst_n)
		reg_rdata[`TTA_RSV_HI_MSB:`TTA_RSV_HI_LSB] == `TTA_RSV_HI_ZERO
		&& reg_rdata[`TTA_RSV_LO_MSB:`TTA_RSV_LO_LSB] == `TTA_RSV_LO_ZERO)
		else $error("reserved bits read nonzero");
	// lock bits only move up until the next reset
	a_win_lock_stays: assert property (@(posedge clock) disable iff (!rst_n)
		win_lock_q |=> win_lock_q)
		else $error("window lock bit cleared");

	a_crit_lock_stays: assert property (@(posedge clock) disable iff (!rst_n)
		crit_lock_q |=> crit_lock_q)
		else $error("critical lock bit cleared");

	a_window_lock_frozen: assert property (@(posedge clock) disable iff (!rst_n)
		win_lock_q |=> $stable(upper_threshold_value) && $stable(lower_threshold_value))
		else $error("window threshold changed under lock");
	a_crit_lock_frozen: assert property (@(posedge clock) disable iff (!rst_n)
		crit_lock_q |=> $stable(critical_threshold_value))
		else $error("critical threshold changed under lock");
	a_access_acked: assert property (@(posedge clock) disable iff (!rst_n)
		req.wr || req.rd |=> req_ack)
		else $error("access not acknowledged");
	a_upper_trip_set: assert property (@(posedge clock) disable iff (!rst_n)
		t_ext > up_ext |=> flags_q.upper)
		else $error("upper flag missed crossing");
	a_lower_trip_set: assert property (@(posedge clock) disable iff (!rst_n)
		t_ext < lo_ext - h_ext |=> flags_q.lower)
		else $error("lower flag missed crossing");
	a_crit_hold_band: assert property (@(posedge clock) disable iff (!rst_n)
		flags_q.crit && t_ext > cr_ext - h_ext |=> flags_q.crit)
		else $error("critical flag released early");
	a_alarm_needs_en: assert property (@(posedge clock) disable iff (!rst_n)
		alarm_out |-> $past(alarm_output_enable))
		else $error("alarm driven while disabled");
	a_crit_only_mask: assert property (@(posedge clock) disable iff (!rst_n)
		alarm_out && $past(critical_only) |-> $past(flags_q.crit))
		else $error("window alarm in critical-only mode");

	// register port answers
	a_access_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		!access |=> !req_ack)
		else $error("acknowledge without an access");

	a_read_upper_value: assert property (@(posedge clock) disable iff (!rst_n)
		req.rd && sel_upper |=>
			reg_rdata[`TTA_FLD_SIGN:`TTA_FLD_LSB] == $past(upper_threshold_value))
		else $error("upper threshold read back wrong");

	a_read_lower_value: assert property (@(posedge clock) disable iff (!rst_n)
		req.rd && sel_lower |=>
			reg_rdata[`TTA_FLD_SIGN:`TTA_FLD_LSB] == $past(lower_threshold_value))
		else $error("lower threshold read back wrong");

	a_read_crit_value: assert property (@(posedge clock) disable iff (!rst_n)
		req.rd && sel_crit |=>
			reg_rdata[`TTA_FLD_SIGN:`TTA_FLD_LSB] == $past(critical_threshold_value))
		else $error("critical threshold read back wrong");

	// an unmapped index must not leak a neighbour's value
	a_read_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n)
		req.rd && sel_none |=> reg_rdata == `TTA_RDATA_ZERO)
		else $error("unmapped index read nonzero");

	a_unmapped_write_ignored: assert property (@(posedge clock) disable iff (!rst_n)
		req.wr && sel_none |=> $stable(upper_threshold_value)
			&& $stable(lower_threshold_value) && $stable(critical_threshold_value))
		else $error("unmapped write changed a threshold");

	// read word is held between reads, so a slow host may pick it up late
	a_rdata_held: assert property (@(posedge clock) disable iff (!rst_n)
		!req.rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");

	// flag transitions at both edges of each band
	a_upper_hold_band: assert property (@(posedge clock) disable iff (!rst_n)
		flags_q.upper && t_ext > up_ext - h_ext |=> flags_q.upper)
		else $error("upper flag released early");

	a_upper_release: assert property (@(posedge clock) disable iff (!rst_n)
		flags_q.upper && t_ext <= up_ext - h_ext |=> !flags_q.upper)
		else $error("upper flag not released");

	a_upper_stays_off: assert property (@(posedge clock) disable iff (!rst_n)
		!flags_q.upper && t_ext <= up_ext |=> !flags_q.upper)
		else $error("upper flag set without crossing");

	a_lower_hold_band: assert property (@(posedge clock) disable iff (!rst_n)
		flags_q.lower && t_ext < lo_ext |=> flags_q.lower)
		else $error("lower flag released early");

	a_lower_release: assert property (@(posedge clock) disable iff (!rst_n)
		t_ext >= lo_ext |=> !flags_q.lower)
		else $error("lower flag not released");

	a_lower_stays_off: assert property (@(posedge clock) disable iff (!rst_n)
		!flags_q.lower && t_ext >= lo_ext - h_ext |=> !flags_q.lower)
		else $error("lower flag set without crossing");

	a_crit_trip_set: assert property (@(posedge clock) disable iff (!rst_n)
		t_ext > cr_ext |=> flags_q.crit)
		else $error("critical flag missed crossing");

	a_crit_release: assert property (@(posedge clock) disable iff (!rst_n)
		t_ext <= cr_ext - h_ext |=> !flags_q.crit)
		else $error("critical flag not released");

	a_crit_stays_off: assert property (@(posedge clock) disable iff (!rst_n)
		!flags_q.crit && t_ext <= cr_ext |=> !flags_q.crit)
		else $error("critical flag set without crossing");

	// alarm pin decision, one cycle behind the flags
	a_alarm_on_crit: assert property (@(posedge clock) disable iff (!rst_n)
		alarm_output_enable && flags_q.crit |=> alarm_out)
		else $error("alarm missed critical flag");

	a_alarm_on_window: assert property (@(posedge clock) disable iff (!rst_n)
		alarm_output_enable && !critical_only
			&& (flags_q.upper || flags_q.lower) |=> alarm_out)
		else $error("alarm missed window flag");

	a_alarm_window_masked: assert property (@(posedge clock) disable iff (!rst_n)
		critical_only && !flags_q.crit |=> !alarm_out)
		else $error("window flag reached alarm in critical-only mode");

	a_alarm_off_disabled: assert property (@(posedge clock) disable iff (!rst_n)
		!alarm_output_enable |=> !alarm_out)
		else $error("alarm stayed on while disabled");

	a_alarm_clear_flags: assert property (@(posedge clock) disable iff (!rst_n)
		!flags_q.crit && !flags_q.upper && !flags_q.lower |=> !alarm_out)
		else $error("alarm without any flag");

	// lock inputs take effect on the next edge
	a_win_lock_taken: assert property (@(posedge clock) disable iff (!rst_n)
		window_lock_set |=> win_lock_q)
		else $error("window lock request lost");

	a_crit_lock_taken: assert property (@(posedge clock) disable iff (!rst_n)
		critical_lock_set |=> crit_lock_q)
		else $error("critical lock request lost");
endmodule : tta_top

// *** tta_top_bench.sv ***
// self-checking bench for the temperature trip threshold block
`timescale 1ns/10ps
module tta_top_bench;
	logic                clock, rst_n, wl_set, cl_set, en, c_only, ack, wl_bit, cl_bit, alm;
	logic                wl_e, cl_e;
	logic [15:0]         rdata;
	logic [11:0]         hyst;
	tta_pkg::tta_temp_t  temp;
	tta_pkg::tta_req_s   req;
	tta_pkg::tta_flags_s flags, exp_f;
	tta_pkg::tta_thr_t   thr [4];
	int                  error_cnt, n_checks;

	tta_top i_dut (.clock(clock), .rst_n(rst_n), .req(req), .req_ack(ack), .reg_rdata(rdata),
		.window_lock_set(wl_set), .critical_lock_set(cl_set), .window_lock_bit(wl_bit),
		.critical_lock_bit(cl_bit), .alarm_output_enable(en), .critical_only(c_only),
		.temp_value(temp), .hysteresis(hyst), .trip_flags(flags), .alarm_out(alm));
	tta_host host (.clock(clock), .req_ack(ack), .reg_rdata(rdata), .req(req));

	initial begin
		clock = 0;
		forever #20 clock = !clock;
	end
	// watchdog sized well above the longest expected run
	initial begin
		#800000;
		error_cnt++;
		give_verdict();
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// k 0..2 are the thresholds, k 3 lands on an unmapped index
	task automatic acc(input logic w, input int k, input logic [15:0] d);
		logic        a;
		logic [15:0] x;
		host.access(w, 8'(k + 2), d, a, x);
		check("ack", {15'h0000, a}, 16'h0001);
		if (w && k < 3 && !(k < 2 ? wl_e : cl_e)) thr[k] = d[12:2];
		if (!w) check("rdata", x, k < 3 ? {3'h0, thr[k], 2'h0} : 16'h0000);
	endtask : acc
	// inputs held steady, so one step of the flag model matches any number of edges
	task automatic settle();
		int t, h, v[3];
		logic ea;
		repeat (3) @(negedge clock);
		t = temp;
		h = int'(hyst);
		for (int k = 0; k < 3; k++) v[k] = 2 * int'(thr[k]);
		if (t > v[0]) exp_f.upper = 1; else if (t <= v[0] - h) exp_f.upper = 0;
		if (t < v[1] - h) exp_f.lower = 1; else if (t >= v[1]) exp_f.lower = 0;
		if (t > v[2]) exp_f.crit = 1; else if (t <= v[2] - h) exp_f.crit = 0;
		check("flags", {13'h0000, flags}, {13'h0000, exp_f});
		ea = en & (exp_f.crit | (!c_only & (exp_f.upper | exp_f.lower)));
		check("alarm", {15'h0000, alm}, {15'h0000, ea});
		check("locks", {14'h0000, cl_bit, wl_bit}, {14'h0000, cl_e, wl_e});
	endtask : settle

	initial begin
		void'($urandom(32'hb3999b3d));
		{rst_n, wl_set, cl_set, en, c_only, temp, hyst, wl_e, cl_e} = '0;
		thr = '{default: '0};
		exp_f = '0;
		repeat (16) @(negedge clock);
		rst_n = 1;
		for (int k = 0; k < 4; k++) acc(0, k, 16'h0000);
		acc(1, 0, 16'hffff);
		acc(0, 0, 16'h0000);
		for (int i = 0; i < 40; i++) begin
			// window lock then critical lock, applied as one-cycle pulses
			if (i == 25 || i == 33) begin
				@(negedge clock);
				{cl_set, wl_set} = (i == 25) ? 2'b01 : 2'b10;
				@(negedge clock);
				{cl_set, wl_set} = 2'b00;
				{cl_e, wl_e} = (i == 25) ? 2'b01 : 2'b11;
			end
			for (int k = 0; k < 4; k++) begin
				acc(1, k, 16'($urandom));
				acc(0, k, 16'h0000);
			end
			settle();
			repeat (3) begin
				@(negedge clock);
				temp = 12'(2 * int'(thr[$urandom_range(0, 2)]) + int'($urandom_range(0, 16)) - 8);
				hyst = 12'($urandom_range(0, 12));
				en = 1'($urandom);
				c_only = 1'($urandom);
				settle();
			end
		end
		// a second reset must clear locks and thresholds
		@(negedge clock);
		rst_n = 0;
		repeat (2) @(negedge clock);
		rst_n = 1;
		{wl_e, cl_e} = 2'b00;
		exp_f = '0;
		thr = '{default: '0};
		for (int k = 0; k < 3; k++) acc(0, k, 16'h0000);
		settle();
		give_verdict();
	end
endmodule : tta_top_bench
